/* common/pbwc_if.sv */
// link between cpu end and bridge end
// assumes both ends share clk
interface pbwc_if;
  logic        req;
  logic        wr;
  logic [31:0] addr;
  logic [1:0]  size;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        done;
  logic        busy;

  modport bridge (input req, wr, addr, size, wdata, output rdata, done, busy);
  modport cpu    (output req, wr, addr, size, wdata, input rdata, done, busy);
endinterface

/* common/pbwc_pkg.sv */
// constants for the peripheral bus wait control block
// assumes one system clock shared by cpu side and bridge side
// ==========================================================
package pbwc_pkg;
  localparam logic [31:0] PBWC_WAIT_CTRL_ADDR = 32'hfffff06e;
  localparam logic [7:0]  PBWC_WAIT_CTRL_RST  = 8'h77;
  localparam logic [7:0]  PBWC_WAIT_CTRL_MASK = 8'h77;
  localparam int          PBWC_SETUP_LSB      = 4;
  localparam int          PBWC_DATA_LSB       = 0;
  localparam int          PBWC_CNT_W          = 3;
  localparam logic [3:0]  PBWC_BASE_CYCLES    = 4'h3;
  localparam logic [1:0]  PBWC_SIZE_BYTE      = 2'h0;
  localparam logic [1:0]  PBWC_SIZE_HALF      = 2'h1;
  localparam logic [1:0]  PBWC_SIZE_WORD      = 2'h2;
  localparam logic [7:0]  PBWC_SET_16MHZ      = 8'h00;
  localparam logic [7:0]  PBWC_SET_25MHZ      = 8'h01;

  typedef enum logic [3:0]
  {
    PBWC_IDLE  = 4'h1,
    PBWC_SETUP = 4'h2,
    PBWC_BASE  = 4'h4,
    PBWC_DWAIT = 4'h8
  } pbwc_state_t;
endpackage

/* tb/pbwc_chk.sv */
// checker: watches the link between the cpu end and the bridge end
// assumes one clock and a register shadow rebuilt from the link
module pbwc_chk
  import pbwc_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        req,
  input wire logic        wr,
  input wire logic [31:0] addr,
  input wire logic [1:0]  size,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        done,
  input wire logic        busy,
  input wire logic        clk_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // shadow and counter
  logic [7:0] reg_q;
  logic [4:0] cnt_q;
  logic [4:0] lat;
  logic       hit;
  assign hit = addr == PBWC_WAIT_CTRL_ADDR;
  assign lat = 5'(PBWC_BASE_CYCLES) + 5'(reg_q[6:4]) + 5'(reg_q[2:0]);
  // new value only counts from the next access
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      reg_q <= PBWC_WAIT_CTRL_RST;
    else if (clk_en && done && wr && hit && size == PBWC_SIZE_BYTE)
      reg_q <= wdata[7:0] & PBWC_WAIT_CTRL_MASK;
  // frozen cycles are not access cycles
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      cnt_q <= 5'h00;
    else if (clk_en)
      cnt_q <= done ? 5'h00 : cnt_q + 5'(req);
  // ====================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n || !clk_en);
  a_done_pulse: assert property (done |=> !done)
    else $error("done held");
  a_access_len: assert property (done |-> cnt_q == lat)
    else $error("access length");
  a_no_overrun: assert property (req && !done |-> cnt_q < lat)
    else $error("access overrun");
  a_reg_readback: assert property (done && !wr && hit |-> rdata[7:0] == reg_q)
    else $error("register readback");
  a_done_with_req: assert property (done |-> req)
    else $error("done without request");
  a_req_drop: assert property (done |=> !req)
    else $error("request after done");
  a_req_held: assert property (req && !done |=> req && $stable({addr, wr, wdata}))
    else $error("request moved");
  a_byte_size: assert property (req && hit |-> size == PBWC_SIZE_BYTE)
    else $error("register size");
  a_busy_stall: assert property (req && !done && cnt_q != 5'h00 |-> busy)
    else $error("busy low in access");
  a_busy_clear: assert property (done |-> !busy)
    else $error("busy at done");
  c_reg_wr: cover property (done && wr && hit);
  c_per_wr: cover property (done && wr && !hit);
  c_reg_rd: cover property (done && !wr && hit);
  c_per: cover property (done && !hit);
endmodule

/* tb/pbwc_test.sv */
// bench: drives the cpu end, the bridge end answers
// assumes a 40 MHz clock and the package constants
module pbwc_test
  import pbwc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] REG_A = PBWC_WAIT_CTRL_ADDR;
  logic        clk, reset_n, cmd_valid, cmd_wr, cmd_ready, rsp_valid, clk_en, per_sel, per_wr, stall;
  logic [31:0] cmd_addr, cmd_wdata, rsp_rdata, per_rdata, per_addr, per_wdata;
  logic [7:0]  wait_ctrl;
  int          n_errors, n_checks, cyc, n_sel;
  pbwc_if pbwc_if_i ();
  pbwc_bridge pbwc_bridge_i (.clk, .reset_n, .clk_en, .bus(pbwc_if_i), .per_sel, .per_wr,
    .per_addr, .per_wdata, .per_rdata, .wait_ctrl);
  pbwc_cpu pbwc_cpu_i (.clk, .reset_n, .clk_en, .bus(pbwc_if_i), .cmd_valid, .cmd_wr,
    .cmd_addr, .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_rdata, .stall);
  pbwc_chk pbwc_chk_i (.clk, .reset_n, .req(pbwc_if_i.req), .wr(pbwc_if_i.wr), .addr(pbwc_if_i.addr),
    .size(pbwc_if_i.size), .wdata(pbwc_if_i.wdata), .rdata(pbwc_if_i.rdata), .done(pbwc_if_i.done),
    .busy(pbwc_if_i.busy), .clk_en);
  // peripheral select seen at falling edges
  always @(negedge clk)
    if (per_sel === 1'b1)
      n_sel++;
  // ====================
  // clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  // ====================
  // shared tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // n counts link cycles with the request up and not yet done
  task acc(input logic w, input logic [31:0] a, d, output logic [31:0] r, n);
    int t;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_wr = w;
    cmd_addr = a;
    cmd_wdata = d;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    n = 32'h0;
    t = 0;
    do
    begin
      @(negedge clk);
      cmd_valid = 1'b0;
      if (stall === 1'b1 && pbwc_if_i.done !== 1'b1)
        n++;
      t++;
    end
    while (rsp_valid !== 1'b1 && t < 100);
    r = rsp_rdata;
  endtask
  task print_verdict;
    $display("errors=%0d checks=%0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ====================
  // scenarios
  task s_reset;
    logic [31:0] r, n;
    chk({24'h0, wait_ctrl}, 32'h77);
    acc(1'b0, REG_A, 32'h0, r, n);
    chk({24'h0, r[7:0]}, 32'h77);
    chk(n, 32'h11);
  endtask
  // every field value, bits 7 and 3 written high to see them dropped
  task s_fields;
    logic [31:0] r, n, lat;
    logic [2:0]  s, w;
    lat = 32'h11;
    for (int i = 0; i < 8; i++)
    begin
      s = 3'(i);
      w = s ^ 3'h5;
      acc(1'b1, REG_A, {24'h0, 1'b1, s, 1'b1, w}, r, n);
      chk(n, lat);
      lat = 32'h3 + 32'(s) + 32'(w);
      chk({24'h0, wait_ctrl}, {24'h0, 1'b0, s, 1'b0, w});
      acc(1'b0, REG_A, 32'h0, r, n);
      chk({24'h0, r[7:0]}, {24'h0, 1'b0, s, 1'b0, w});
      chk(n, lat);
    end
    chk(32'(n_sel), 32'h0);
  endtask
  // recommended settings, then reads and writes beyond the bridge
  task s_periph;
    logic [31:0] r, n;
    for (int k = 0; k < 2; k++)
    begin
      acc(1'b1, REG_A, 32'(k), r, n);
      per_rdata = 32'h5a3c0f00 + 32'(k);
      n_sel = 0;
      acc(1'b0, 32'h00001000, 32'h0, r, n);
      chk(r, 32'h5a3c0f00 + 32'(k));
      chk(32'(n_sel > 0), 32'h1);
      chk(32'(per_wr), 32'h0);
      chk(n, 32'h3 + 32'(k));
      acc(1'b1, 32'h00002004, 32'hc3, r, n);
      chk(per_addr, 32'h00002004);
      chk(per_wdata, 32'hc3);
      chk(32'(per_wr), 32'h1);
      chk(n, 32'h3 + 32'(k));
    end
  endtask
  // enable dropped for five cycles inside a read: access stretches by five
  task s_freeze;
    logic [31:0] r, n;
    fork
      acc(1'b0, REG_A, 32'h0, r, n);
      begin
        repeat (3) @(negedge clk);
        clk_en = 1'b0;
        repeat (5) @(negedge clk);
        clk_en = 1'b1;
      end
    join
    chk(r, 32'h01);
    chk(n, 32'h9);
  endtask
  // reset in mid-run restores the default, then software programs it again
  task s_rerun;
    logic [31:0] r, n;
    @(negedge clk);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    chk({24'h0, wait_ctrl}, 32'h77);
    reset_n = 1'b1;
    acc(1'b1, REG_A, 32'(PBWC_SET_25MHZ), r, n);
    chk(n, 32'h11);
    acc(1'b0, REG_A, 32'h0, r, n);
    chk(r, 32'h01);
    chk(n, 32'h4);
  endtask
  initial
  begin
    n_errors = 0;
    n_checks = 0;
    cyc = 0;
    n_sel = 0;
    clk_en = 1'b1;
    reset_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_wr = 1'b0;
    cmd_addr = 32'h0;
    cmd_wdata = 32'h0;
    per_rdata = 32'h0;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    s_reset();
    s_fields();
    s_periph();
    s_freeze();
    s_rerun();
    print_verdict();
  end
endmodule

/* verilog/pbwc_bridge.sv */
// bridge end: holds the wait control register and times peripheral accesses
// assumes cpu end holds a request steady until done; one clock domain
module pbwc_bridge
  import pbwc_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  reset_n,
  input  wire logic  clk_en,
  pbwc_if.bridge     bus,
  output logic       per_sel,
  output logic       per_wr,
  output logic [31:0] per_addr,
  output logic [31:0] per_wdata,
  input  wire logic [31:0] per_rdata,
  output logic [7:0] wait_ctrl
);
  // ==========================================================
  // register
  logic [7:0]        periph_wait_ctrl_q;
  pbwc_state_t       state_q;
  logic [2:0]        cnt_q;
  logic [2:0]        addr_setup_wait_cnt;
  logic [2:0]        data_wait_cnt;
  logic              hit;
  logic              done_q;
  logic              busy_q;
  logic [31:0]       rdata_q;
  logic              wr_q;
  logic [31:0]       addr_q;
  logic [31:0]       wdata_q;
  logic              sel_q;

  assign addr_setup_wait_cnt = periph_wait_ctrl_q[PBWC_SETUP_LSB +: PBWC_CNT_W];
  assign data_wait_cnt       = periph_wait_ctrl_q[PBWC_DATA_LSB +: PBWC_CNT_W];
  assign hit = (addr_q == PBWC_WAIT_CTRL_ADDR);

  // write lands at end of access, so next access sees it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      periph_wait_ctrl_q <= PBWC_WAIT_CTRL_RST;
    else if (clk_en && state_q != PBWC_IDLE && cnt_q == 3'h0 && state_q == PBWC_BASE
             && data_wait_cnt == 3'h0 && hit && wr_q && bus.size == PBWC_SIZE_BYTE)
      periph_wait_ctrl_q <= wdata_q[7:0] & PBWC_WAIT_CTRL_MASK;
    else if (clk_en && state_q == PBWC_DWAIT && cnt_q == 3'h0 && hit && wr_q
             && bus.size == PBWC_SIZE_BYTE)
      periph_wait_ctrl_q <= wdata_q[7:0] & PBWC_WAIT_CTRL_MASK;
  end

  // ==========================================================
  // access sequencer, every count in system clocks
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= PBWC_IDLE;
      cnt_q   <= 3'h0;
    end
    else if (clk_en)
    begin
      case (state_q)
        PBWC_IDLE:
        begin
          if (bus.req && !done_q)
          begin
            if (addr_setup_wait_cnt != 3'h0)
            begin
              state_q <= PBWC_SETUP;
              cnt_q   <= addr_setup_wait_cnt - 3'h1;
            end
            else
            begin
              state_q <= PBWC_BASE;
              cnt_q   <= 3'h1;
            end
          end
        end
        PBWC_SETUP:
        begin
          if (cnt_q == 3'h0)
          begin
            state_q <= PBWC_BASE;
            cnt_q   <= 3'h1;
          end
          else
            cnt_q <= cnt_q - 3'h1;
        end
        PBWC_BASE:
        begin
          if (cnt_q != 3'h0)
            cnt_q <= cnt_q - 3'h1;
          else if (data_wait_cnt != 3'h0)
          begin
            state_q <= PBWC_DWAIT;
            cnt_q   <= data_wait_cnt - 3'h1;
          end
          else
            state_q <= PBWC_IDLE;
        end
        PBWC_DWAIT:
        begin
          if (cnt_q == 3'h0)
            state_q <= PBWC_IDLE;
          else
            cnt_q <= cnt_q - 3'h1;
        end
        default:
        begin
          state_q <= PBWC_IDLE;
          cnt_q   <= 3'h0;
        end
      endcase
    end
  end

  // latch request at start
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_q    <= 1'b0;
      addr_q  <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
    end
    else if (clk_en && state_q == PBWC_IDLE && bus.req && !done_q)
    begin
      wr_q    <= bus.wr;
      addr_q  <= bus.addr;
      wdata_q <= bus.wdata;
    end
  end

  // ==========================================================
  // answer: done pulses after 3+setup+data cycles
  logic finishing;
  assign finishing = (state_q == PBWC_BASE && cnt_q == 3'h0 && data_wait_cnt == 3'h0)
                     || (state_q == PBWC_DWAIT && cnt_q == 3'h0);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      done_q  <= 1'b0;
      busy_q  <= 1'b0;
      rdata_q <= 32'h0000_0000;
      sel_q   <= 1'b0;
    end
    else if (clk_en)
    begin
      done_q <= finishing;
      busy_q <= (state_q == PBWC_IDLE) ? (bus.req && !done_q) : !finishing;
      sel_q  <= (state_q == PBWC_BASE) && !hit;
      if (finishing && !wr_q)
        rdata_q <= hit ? {24'h000000, periph_wait_ctrl_q} : per_rdata;
    end
  end

  assign bus.done   = done_q;
  assign bus.busy   = busy_q;
  assign bus.rdata  = rdata_q;
  assign per_sel    = sel_q;
  assign per_wr     = wr_q;
  assign per_addr   = addr_q;
  assign per_wdata  = wdata_q;
  assign wait_ctrl  = periph_wait_ctrl_q;
endmodule

/* verilog/pbwc_cpu.sv */
// cpu end: issues one peripheral access and stalls until it is done
// assumes the bridge end answers with a one-cycle done
module pbwc_cpu
  import pbwc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  pbwc_if.cpu              bus,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_wr,
  input  wire logic [31:0] cmd_addr,
  input  wire logic [31:0] cmd_wdata,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic [31:0]      rsp_rdata,
  output logic             stall
);
  // ==========================================================
  logic        req_q;
  logic        wr_q;
  logic [31:0] addr_q;
  logic [31:0] wdata_q;
  logic        rsp_q;
  logic [31:0] rdata_q;
  logic        ready_q;

  // one outstanding access; cpu frozen meanwhile
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      req_q   <= 1'b0;
      wr_q    <= 1'b0;
      addr_q  <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      rsp_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      ready_q <= 1'b1;
    end
    else if (clk_en)
    begin
      rsp_q   <= 1'b0;
      // ready is registered: it mirrors no request and no response next cycle
      ready_q <= !req_q;
      if (req_q && bus.done)
      begin
        req_q   <= 1'b0;
        rsp_q   <= 1'b1;
        ready_q <= 1'b0;
        rdata_q <= bus.rdata;
      end
      else if (!req_q && cmd_valid && !rsp_q)
      begin
        req_q   <= 1'b1;
        ready_q <= 1'b0;
        wr_q    <= cmd_wr;
        addr_q  <= cmd_addr;
        // reserved bits forced to zero
        wdata_q <= (cmd_addr == PBWC_WAIT_CTRL_ADDR) ? (cmd_wdata & {24'h000000, PBWC_WAIT_CTRL_MASK})
                                                     : cmd_wdata;
      end
    end
  end

  assign bus.req   = req_q;
  assign bus.wr    = wr_q;
  assign bus.addr  = addr_q;
  assign bus.size  = PBWC_SIZE_BYTE;
  assign bus.wdata = wdata_q;
  assign cmd_ready = ready_q;
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
  assign stall     = req_q;
endmodule
